// ---- logic/pin_sync.v ----
// two-stage synchroniser, advanced on standby ticks
`timescale 1ns/1ps
`include "wake_consts.vh"
module pin_sync (
  input  wire                mclk_i,
  input  wire                reset_i,
  input  wire                tick_i,
  input  wire [`WK_N-1:0]    pin_i,
  output wire [`WK_N-1:0]    pin_o
);

  reg [`WK_N-1:0] meta_ff;
  reg [`WK_N-1:0] stab_ff;

  // ==================================================
  // synchroniser stages
  always @(posedge mclk_i) begin
    if (reset_i) begin
      meta_ff <= {`WK_N{1'b0}};
      stab_ff <= {`WK_N{1'b0}};
    end else if (tick_i) begin
      meta_ff <= pin_i;
      stab_ff <= meta_ff;
    end
  end

  assign pin_o = stab_ff;
endmodule

// ---- logic/retain_ram.v ----
// retained memory, writes gated while suspended
`timescale 1ns/1ps
`include "wake_consts.vh"
module retain_ram (
  input  wire                mclk_i,
  input  wire                suspend_i,
  input  wire                we_i,
  input  wire [`RAM_AW-1:0]  adr_i,
  input  wire [7:0]          wdat_i,
  output wire [7:0]          rdat_o
);

  reg [7:0] mem_ff [0:`RAM_DEPTH-1];

  // ==================================================
  // storage, no reset so contents survive
  always @(posedge mclk_i) begin
    if (we_i && !suspend_i) begin
      mem_ff[adr_i] <= wdat_i;
    end
  end

  assign rdat_o = mem_ff[adr_i];
endmodule

// ---- logic/wake_consts.vh ----
// constants for the signature wake controller
`ifndef WAKE_CONSTS_VH
`define WAKE_CONSTS_VH

// number of wake pins
`define WK_N          4
`define WK_NW         3
// per-pin wake mode encoding
`define WM_OFF        2'h0
`define WM_ON1        2'h1
`define WM_ON0        2'h2
`define WM_CHG        2'h3
// register offsets
`define A_CTRL        4'h0
`define A_MODE        4'h1
`define A_STAT        4'h2
`define A_IRQ_ST      4'h3
`define A_IRQ_MSK     4'h4
`define A_RAM_ADR     4'h5
`define A_RAM_DAT     4'h6
`define A_CNT         4'h7
`define A_CAPS        4'h8
// reset values
`define RST_MODE      8'h5A
`define RST_CAPS      4'hF
`define RST_CTRL      2'h1
// control bits
`define C_SUSPEND     0
`define C_SWFREEZE    1
// status and interrupt bits
`define I_ENTER       0
`define I_EXIT        1
`define I_SIG         2
`define I_TOG         3
// retained memory
`define RAM_DEPTH     16
`define RAM_AW        4
// standby tick divider, 125 MHz down to 1 MHz
`define CLK_MHZ       125
`define SBY_MHZ       1
`define SBY_DIV       (`CLK_MHZ / `SBY_MHZ)
`define DIV_W         7

`endif

// ---- logic/wake_ctrl.v ----
// signature wake controller top level
`timescale 1ns/1ps
`include "wake_consts.vh"
module wake_ctrl (
  input  wire                mclk_i,
  input  wire                reset_i,
  input  wire                freeze_request_i,
  input  wire [`WK_N-1:0]    wake_pin_i,
  input  wire [3:0]          adr_i,
  input  wire [7:0]          wdat_i,
  input  wire                wr_i,
  input  wire                rd_i,
  output reg  [7:0]          rdat_o,
  output reg                 frozen_o,
  output reg                 run_en_o,
  output reg  [7:0]          user_cnt_o,
  output reg                 irq_o
);

  // state codes, one-hot
  localparam [1:0] S_ACTIVE = 2'b01;
  localparam [1:0] S_FROZEN = 2'b10;

  reg  [1:0]             state_ff;
  reg  [1:0]             nxt_state;
  reg  [1:0]             ctrl_ff;
  reg  [7:0]             mode_ff;
  reg  [`WK_N-1:0]       caps_ff;
  reg  [3:0]             irq_st_ff;
  reg  [3:0]             irq_msk_ff;
  reg  [`RAM_AW-1:0]     ram_adr_ff;
  reg  [`DIV_W-1:0]      div_ff;
  reg                    tick_ff;
  reg                    req_d_ff;
  reg  [`WK_N-1:0]       prev_ff;
  reg                    prev_vld_ff;
  wire [`WK_N-1:0]       pin_s;
  wire [7:0]             ram_rdat;
  wire                   req_edge;
  wire                   sw_req;
  wire                   sig_hit;
  wire                   sig_any;
  wire                   tog_hit;
  wire                   wake;
  wire [3:0]             ev;
  integer                i;

  // per-pin mode lookup
  function [1:0] pin_mode;
    input [7:0] m;
    input [`WK_NW-1:0] k;
    begin
      pin_mode = m[k*2 +: 2];
    end
  endfunction

  // ==================================================
  // standby tick divider
  always @(posedge mclk_i) begin
    if (reset_i) begin
      div_ff  <= {`DIV_W{1'b0}};
      tick_ff <= 1'b0;
    end else if (div_ff == `SBY_DIV - 1) begin
      div_ff  <= {`DIV_W{1'b0}};
      tick_ff <= 1'b1;
    end else begin
      div_ff  <= div_ff + 1'b1;
      tick_ff <= 1'b0;
    end
  end

  pin_sync u_sync (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .tick_i  (tick_ff),
    .pin_i   (wake_pin_i),
    .pin_o   (pin_s)
  );

  // ==================================================
  // wake matching
  reg [`WK_N-1:0] lvl_ok;
  reg [`WK_N-1:0] lvl_use;
  reg [`WK_N-1:0] tog_use;
  always @* begin
    lvl_ok  = {`WK_N{1'b1}};
    lvl_use = {`WK_N{1'b0}};
    tog_use = {`WK_N{1'b0}};
    for (i = 0; i < `WK_N; i = i + 1) begin
      case (pin_mode(mode_ff, i[`WK_NW-1:0]))
        `WM_ON1: begin
          lvl_use[i] = caps_ff[i];
          lvl_ok[i]  = pin_s[i] | ~caps_ff[i];
        end
        `WM_ON0: begin
          lvl_use[i] = caps_ff[i];
          lvl_ok[i]  = ~pin_s[i] | ~caps_ff[i];
        end
        `WM_CHG: begin
          tog_use[i] = caps_ff[i];
        end
        default: begin
          lvl_ok[i] = 1'b1;
        end
      endcase
    end
  end

  assign sig_any = |lvl_use;
  assign sig_hit = sig_any & (&lvl_ok);
  assign tog_hit = prev_vld_ff &
                   (|((pin_s ^ prev_ff) & tog_use));
  assign wake    = sig_hit | tog_hit;

  always @(posedge mclk_i) begin
    if (reset_i) begin
      prev_ff     <= {`WK_N{1'b0}};
      prev_vld_ff <= 1'b0;
    end else begin
      prev_ff     <= pin_s;
      prev_vld_ff <= tick_ff | prev_vld_ff;
    end
  end

  // ==================================================
  // request edge detect
  always @(posedge mclk_i) begin
    if (reset_i) begin
      req_d_ff <= 1'b0;
    end else begin
      req_d_ff <= freeze_request_i;
    end
  end
  // press-and-release: act on the falling edge
  assign req_edge = req_d_ff & ~freeze_request_i;
  assign sw_req   = wr_i && (adr_i == `A_CTRL) && wdat_i[`C_SWFREEZE];

  // ==================================================
  // freeze state machine
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      S_ACTIVE: begin
        if ((req_edge | sw_req) && !wake) begin
          nxt_state = S_FROZEN;
        end
      end
      S_FROZEN: begin
        if (wake) begin
          nxt_state = S_ACTIVE;
        end
      end
      default: begin
        nxt_state = S_ACTIVE;
      end
    endcase
  end

  assign ev[`I_ENTER] = (state_ff == S_ACTIVE) &&
                        (nxt_state == S_FROZEN);
  assign ev[`I_EXIT]  = (state_ff == S_FROZEN) &&
                        (nxt_state == S_ACTIVE);
  assign ev[`I_SIG]   = ev[`I_EXIT] & sig_hit;
  assign ev[`I_TOG]   = ev[`I_EXIT] & tog_hit;

  always @(posedge mclk_i) begin
    if (reset_i) begin
      state_ff   <= S_ACTIVE;
      frozen_o   <= 1'b0;
      run_en_o   <= 1'b1;
      user_cnt_o <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      frozen_o <= (nxt_state == S_FROZEN);
      run_en_o <= (nxt_state == S_ACTIVE);
      if (state_ff == S_ACTIVE) begin
        user_cnt_o <= user_cnt_o + 8'h01;
      end
    end
  end

  // ==================================================
  // retained memory
  retain_ram u_ram (
    .mclk_i    (mclk_i),
    .suspend_i (ctrl_ff[`C_SUSPEND] & (state_ff == S_FROZEN)),
    .we_i      (wr_i && (adr_i == `A_RAM_DAT)),
    .adr_i     (ram_adr_ff),
    .wdat_i    (wdat_i),
    .rdat_o    (ram_rdat)
  );

  // ==================================================
  // register writes
  always @(posedge mclk_i) begin
    if (reset_i) begin
      ctrl_ff    <= `RST_CTRL;
      mode_ff    <= `RST_MODE;
      caps_ff    <= `RST_CAPS;
      irq_msk_ff <= 4'h0;
      ram_adr_ff <= {`RAM_AW{1'b0}};
    end else if (wr_i) begin
      case (adr_i)
        `A_CTRL:    ctrl_ff    <= {1'b0, wdat_i[`C_SUSPEND]};
        `A_MODE:    mode_ff    <= wdat_i;
        `A_CAPS:    caps_ff    <= wdat_i[`WK_N-1:0];
        `A_IRQ_MSK: irq_msk_ff <= wdat_i[3:0];
        `A_RAM_ADR: ram_adr_ff <= wdat_i[`RAM_AW-1:0];
        default:    ram_adr_ff <= ram_adr_ff;
      endcase
    end
  end

  // ==================================================
  // interrupt status, set wins over clear
  always @(posedge mclk_i) begin
    if (reset_i) begin
      irq_st_ff <= 4'h0;
      irq_o     <= 1'b0;
    end else begin
      if (wr_i && (adr_i == `A_IRQ_ST)) begin
        irq_st_ff <= (irq_st_ff & ~wdat_i[3:0]) | ev;
      end else begin
        irq_st_ff <= irq_st_ff | ev;
      end
      irq_o <= |(irq_st_ff & irq_msk_ff);
    end
  end

  // ==================================================
  // register reads
  always @(posedge mclk_i) begin
    if (reset_i) begin
      rdat_o <= 8'h00;
    end else if (rd_i) begin
      case (adr_i)
        `A_CTRL:    rdat_o <= {6'h00, ctrl_ff};
        `A_MODE:    rdat_o <= mode_ff;
        `A_STAT:    rdat_o <= {pin_s, 1'b0, tog_hit, sig_hit,
                               frozen_o};
        `A_IRQ_ST:  rdat_o <= {4'h0, irq_st_ff};
        `A_IRQ_MSK: rdat_o <= {4'h0, irq_msk_ff};
        `A_RAM_ADR: rdat_o <= {4'h0, ram_adr_ff};
        `A_RAM_DAT: rdat_o <= ram_rdat;
        `A_CNT:     rdat_o <= user_cnt_o;
        `A_CAPS:    rdat_o <= {4'h0, caps_ff};
        default:    rdat_o <= 8'h00;
      endcase
    end else begin
      rdat_o <= 8'h00;
    end
  end
endmodule

// ---- sim/switch_bank.sv ----
// switch bank model driving the wake pins
`timescale 1ns/1ps
`include "wake_consts.vh"
module switch_bank (
  input  wire             mclk_i,
  input  wire [`WK_N-1:0] set_i,
  output reg  [`WK_N-1:0] pin_o
);
  initial pin_o = 4'h0;
  // switches settle one cycle after being moved
  always @(posedge mclk_i) begin
    pin_o <= set_i;
  end
endmodule

// ---- sim/wake_ctrl_monitor.sv ----
// assertions on the wake controller ports
`timescale 1ns/1ps
`include "wake_consts.vh"
module wake_ctrl_monitor (
  input wire             mclk_i,
  input wire             reset_i,
  input wire             freeze_request_i,
  input wire [`WK_N-1:0] wake_pin_i,
  input wire [3:0]       adr_i,
  input wire [7:0]       wdat_i,
  input wire             wr_i,
  input wire             rd_i,
  input wire [7:0]       rdat_o,
  input wire             frozen_o,
  input wire             run_en_o,
  input wire [7:0]       user_cnt_o,
  input wire             irq_o
);
  // ==========================================
  // helper counters
  reg [`WK_N-1:0] pin_ff;
  reg             req_ff;
  reg             dirty_ff;
  reg [9:0]       quiet_ff;
  reg [2:0]       act_ff;
  always @(posedge mclk_i) begin
    pin_ff <= wake_pin_i;
    req_ff <= freeze_request_i;
    if (reset_i || wr_i || wake_pin_i != pin_ff)
      quiet_ff <= 10'h000;
    else if (quiet_ff != 10'h3FF)
      quiet_ff <= quiet_ff + 10'h001;
    if (reset_i)
      act_ff <= 3'h7;
    else if (wr_i || (req_ff && !freeze_request_i))
      act_ff <= 3'h0;
    else if (act_ff != 3'h7)
      act_ff <= act_ff + 3'h1;
    if (reset_i)
      dirty_ff <= 1'b0;
    else if (wr_i && (adr_i == `A_MODE || adr_i == `A_CAPS))
      dirty_ff <= 1'b1;
  end
  // ==========================================
  // properties
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  run_inv_a: assert property (run_en_o == !frozen_o)
    else $error("run enable not inverse of frozen");
  cnt_hold_a: assert property (frozen_o && $past(frozen_o) |->
    $stable(user_cnt_o)) else $error("counter moved while frozen");
  cnt_run_a: assert property (!frozen_o && !$past(frozen_o) &&
    !$past(reset_i) |-> user_cnt_o == $past(user_cnt_o) + 8'h01)
    else $error("counter not advancing while active");
  entry_cause_a: assert property ($rose(frozen_o) |->
    act_ff < 3'h4) else $error("freeze without request");
  entry_go_a: assert property ($fell(freeze_request_i) && !frozen_o &&
    !dirty_ff && quiet_ff > 10'h190 && wake_pin_i != 4'hC |->
    ##[1:3] frozen_o) else $error("request did not freeze");
  exit_cause_a: assert property ($fell(frozen_o) |->
    quiet_ff < 10'h190) else $error("wake without pin change");
  rdat_idle_a: assert property (!$past(rd_i) |->
    rdat_o == 8'h00) else $error("read data outside read slot");
  irq_fall_a: assert property ($fell(irq_o) |->
    $past(wr_i) || $past(wr_i, 2) || $past(wr_i, 3))
    else $error("interrupt dropped without write");
endmodule

bind wake_ctrl wake_ctrl_monitor mon (.mclk_i, .reset_i, .freeze_request_i,
  .wake_pin_i, .adr_i, .wdat_i, .wr_i, .rd_i, .rdat_o, .frozen_o,
  .run_en_o, .user_cnt_o, .irq_o);

// ---- sim/wake_ctrl_tb_top.sv ----
// self-checking bench for the wake controller
`timescale 1ns/1ps
`include "wake_consts.vh"
module wake_ctrl_tb_top;
  reg         mclk_i = 1'b0;
  reg         reset_i = 1'b1;
  reg         freeze_request_i = 1'b0;
  reg  [3:0]  sw_set = 4'h0;
  reg  [3:0]  adr_i = 4'h0;
  reg  [7:0]  wdat_i = 8'h00;
  reg         wr_i = 1'b0;
  reg         rd_i = 1'b0;
  wire [3:0]  wake_pin_i;
  wire [7:0]  rdat_o;
  wire [7:0]  user_cnt_o;
  wire        frozen_o, run_en_o, irq_o;
  integer     mismatches = 0, total_checks = 0, cycles = 0, i;
  reg  [31:0] seed = 32'h0000EE03;
  reg  [7:0]  c, d;
  reg  [3:0]  a, p;
  always #4 mclk_i = ~mclk_i;
  switch_bank sw (.mclk_i, .set_i(sw_set), .pin_o(wake_pin_i));
  wake_ctrl dut (.mclk_i, .reset_i, .freeze_request_i, .wake_pin_i,
    .adr_i, .wdat_i, .wr_i, .rd_i, .rdat_o, .frozen_o, .run_en_o,
    .user_cnt_o, .irq_o);
  // ==========================================
  // helpers
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task conclude;
    begin
      if (mismatches == 0 && total_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input string n, input [7:0] e, input [7:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        $display("[ERR] %s expected %h seen %h", n, e, g);
        mismatches = mismatches + 1;
      end
    end
  endtask
  task wr(input [3:0] ad, input [7:0] dt);
    begin
      @(posedge mclk_i);
      adr_i <= ad;
      wdat_i <= dt;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
    end
  endtask
  task rd(input [3:0] ad, input [7:0] e, input string n);
    begin
      @(posedge mclk_i);
      adr_i <= ad;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 chk(n, e, rdat_o);
    end
  endtask
  task pins(input [3:0] v);
    begin
      @(posedge mclk_i);
      sw_set <= v;
      repeat (420) @(posedge mclk_i);
      #1;
    end
  endtask
  task press;
    begin
      @(posedge mclk_i);
      freeze_request_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      freeze_request_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
      #1;
    end
  endtask
  always @(posedge mclk_i) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      conclude;
    end
  end
  // ==========================================
  // scenarios
  initial begin
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    rd(`A_MODE, `RST_MODE, "mode");
    rd(`A_CAPS, {4'h0, `RST_CAPS}, "caps");
    rd(4'hF, 8'h00, "unmapped");
    wr(`A_IRQ_MSK, 8'h03);
    for (i = 0; i < 4; i = i + 1) begin
      seed = xs(seed);
      a = seed[3:0];
      d = seed[11:4];
      p = (seed[15:12] == 4'hC) ? 4'h3 : seed[15:12];
      wr(`A_RAM_ADR, {4'h0, a});
      wr(`A_RAM_DAT, d);
      pins(p);
      press;
      chk("frozen", 8'h01, {7'h0, frozen_o});
      c = user_cnt_o;
      pins(4'hC ^ (4'h1 << i));
      chk("count", c, user_cnt_o);
      chk("partial", 8'h01, {7'h0, frozen_o});
      chk("irq", 8'h01, {7'h0, irq_o});
      wr(`A_RAM_DAT, ~d);
      pins(4'hC);
      chk("woken", 8'h00, {7'h0, frozen_o});
      wr(`A_RAM_ADR, {4'h0, a});
      rd(`A_RAM_DAT, d, "ram");
      wr(`A_IRQ_ST, 8'h0F);
      repeat (3) @(posedge mclk_i);
      #1 chk("irqclr", 8'h00, {7'h0, irq_o});
      press;
      chk("held", 8'h00, {7'h0, frozen_o});
    end
    wr(`A_MODE, 8'h5B);
    wr(`A_IRQ_MSK, 8'h00);
    for (i = 0; i < 2; i = i + 1) begin
      pins({3'h3, i[0]});
      press;
      chk("tfrozen", 8'h01, {7'h0, frozen_o});
      chk("masked", 8'h00, {7'h0, irq_o});
      pins({3'h3, ~i[0]});
      chk("toggle", 8'h00, {7'h0, frozen_o});
    end
    wr(`A_IRQ_MSK, 8'h03);
    repeat (3) @(posedge mclk_i);
    #1 chk("unmask", 8'h01, {7'h0, irq_o});
    wr(`A_CAPS, 8'h0E);
    pins(4'h6);
    press;
    pins(4'h7);
    chk("outonly", 8'h01, {7'h0, frozen_o});
    pins(4'hC);
    chk("sigwake", 8'h00, {7'h0, frozen_o});
    pins(4'h6);
    wr(`A_CTRL, 8'h03);
    rd(`A_STAT, 8'h61, "stat");
    rd(`A_CTRL, 8'h01, "ctrl");
    wr(`A_MODE, 8'h58);
    wr(`A_CAPS, 8'h0F);
    pins(4'h1);
    chk("offpin", 8'h01, {7'h0, frozen_o});
    pins(4'hD);
    chk("offwake", 8'h00, {7'h0, frozen_o});
    conclude;
  end
endmodule
